// [rtl/arc_pkg.sv]
// Package: register map, field layout and types of the analog control block
`default_nettype none
package arc_pkg;
    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_REFERENCE_CONTROL = 8'hD1;
    localparam logic [7:0] ADDR_CMP0_CONTROL      = 8'h9A;
    localparam logic [7:0] ADDR_CMP0_MODE         = 8'h9B;
    localparam logic [7:0] ADDR_CMP1_CONTROL      = 8'h9D;
    localparam logic [7:0] ADDR_CMP1_MODE         = 8'h9E;
    localparam logic [7:0] ADDR_CMP0_INPUT_SELECT = 8'h9F;
    localparam logic [7:0] ADDR_CMP1_INPUT_SELECT = 8'h9C;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int REF_BUFFER_BIT   = 0;
    localparam int REF_BIAS_BIT     = 1;
    localparam int REF_TEMP_BIT     = 2;
    localparam int REF_SOURCE_BIT   = 3;
    localparam int REF_LEVEL_BIT    = 4;
    localparam int REF_ZTC_BIT      = 5;
    localparam int CTL_ENABLE_BIT   = 7;
    localparam int CTL_OUTPUT_BIT   = 6;
    localparam int CTL_RISING_BIT   = 5;
    localparam int CTL_FALLING_BIT  = 4;
    localparam int CTL_HYP_LSB      = 2;
    localparam int CTL_HYN_LSB      = 0;
    localparam int MD_RIE_BIT       = 5;
    localparam int MD_FIE_BIT       = 4;
    localparam int MD_MODE_LSB      = 0;
    localparam int MX_POS_LSB       = 0;
    localparam int MX_NEG_LSB       = 4;

    // ****************************************************************
    // Values after reset
    // ****************************************************************
    localparam logic [3:0] RST_REF_WRITABLE = 4'h0;
    localparam logic [1:0] RST_MODE         = 2'h2;
    localparam logic [1:0] RST_HYST         = 2'h0;
    localparam logic [1:0] RST_INPUT        = 2'h0;
    localparam logic [7:0] RST_READ_DATA    = 8'h00;

    // ****************************************************************
    // Types
    // ****************************************************************
    // Settings that the analog comparator takes from its registers
    typedef struct packed {
        logic       enable;
        logic [1:0] response_mode_field;
        logic [1:0] positive_hysteresis_select;
        logic [1:0] negative_hysteresis_select;
        logic [1:0] positive_input_field;
        logic [1:0] negative_input_field;
    } arc_cmp_cfg_t;

    // Controls that go to the reference, sensor and bias circuits
    typedef struct packed {
        logic reference_source_select;
        logic temp_sensor_enable;
        logic bias_on;
        logic reference_buffer_enable;
    } arc_ref_ctl_t;
endpackage
`default_nettype wire

// [rtl/arc_ctrl.sv]
// Digital control of the voltage reference and the two comparators
//
// Overview of operation
// - Source select bit 0 routes reference pin, 1 routes core supply.
// - Bit 2 of reference control switches temperature sensor on or off.
// - Bias runs when any user needs it; bias enable bit forces it on.
// - Bit 0 drives internal reference onto the reference pin; 0 is off.
// - Read-only level bit: 0 means 1.5 V, 1 means 2.20 V.
// - Read-only bit 5: 0 bias on demand, 1 bias forced on.
// - Reference control bits 7:6 read 00b, writes ignored.
// - Comparator enable bit 1 enables, 0 disables.
// - Disabled comparator drives low on its pin outputs.
// - Falling output sets falling flag, rising output sets rising flag.
// - Edge flags stay set until software clears them.
// - Output state bit shows synchronised comparator output; reads 0 while disabled.
// - Two pin outputs: clock-latched and raw asynchronous.
// - Interrupts can be raised on rising and falling transitions.
// - Input select register holds two-bit positive and negative fields.
// - Comparators identical; only comparator 0 gives a reset source.
// - Response from mode field, hysteresis from control fields.
// - Separate rising and falling interrupt enables, reset to 0.
// - Mode field resets to 10; 00 fastest, 11 slowest.
// - Hysteresis code 00 disables; 01, 10, 11 increase it.
`default_nettype none
module arc_ctrl #(
    parameter int NUM_CMP = 2
) (
    // Clock and reset
    input  wire logic                              ref_clk,
    input  wire logic                              arst_n,
    // Special function register port
    input  wire logic [7:0]                        sfr_addr,
    input  wire logic                              sfr_wr,
    input  wire logic                              sfr_rd,
    input  wire logic [7:0]                        sfr_wdata,
    output logic      [7:0]                        sfr_rdata,
    // Reference status and demand from the analog side, and controls sent to it
    input  wire logic                              reference_level_select,
    input  wire logic                              zero_tc_bias_force,
    input  wire logic                              bias_request,
    output arc_pkg::arc_ref_ctl_t                  ref_ctl,
    // Comparators
    input  wire logic [NUM_CMP-1:0]                cmp_analog_out,
    output arc_pkg::arc_cmp_cfg_t [NUM_CMP-1:0]    cmp_cfg,
    output logic      [NUM_CMP-1:0]                raw_comparator_output,
    output logic      [NUM_CMP-1:0]                latched_cmp_output,
    output logic      [NUM_CMP-1:0]                cmp_irq,
    output logic                                   cmp0_reset_source
);
    // ****************************************************************
    // Reference control
    // ****************************************************************
    logic [3:0] ref_wr_ff;
    logic [3:0] nxt_ref_wr;
    logic       ref_wr_hit;
    logic [7:0] ref_read;

    assign ref_wr_hit = sfr_wr && (sfr_addr == arc_pkg::ADDR_REFERENCE_CONTROL);
    // Bits 7:6 are never stored, so writes there are lost
    assign nxt_ref_wr = ref_wr_hit ? sfr_wdata[3:0] : ref_wr_ff;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_wr_ff <= arc_pkg::RST_REF_WRITABLE;
        end else begin
            ref_wr_ff <= nxt_ref_wr;
        end
    end

    assign ref_ctl.reference_source_select =
        ref_wr_ff[arc_pkg::REF_SOURCE_BIT];
    assign ref_ctl.temp_sensor_enable =
        ref_wr_ff[arc_pkg::REF_TEMP_BIT];
    assign ref_ctl.bias_on =
        ref_wr_ff[arc_pkg::REF_BIAS_BIT] | bias_request;
    assign ref_ctl.reference_buffer_enable =
        ref_wr_ff[arc_pkg::REF_BUFFER_BIT];

    assign ref_read = {2'b00,
                       zero_tc_bias_force,
                       reference_level_select,
                       ref_wr_ff};

    // ****************************************************************
    // Comparator channels
    // ****************************************************************
    logic [7:0] ctl_read [NUM_CMP];
    logic [7:0] md_read  [NUM_CMP];
    logic [7:0] mx_read  [NUM_CMP];

    genvar g;
    generate
        for (g = 0; g < NUM_CMP; g++) begin : g_cmp
            logic [7:0] ctl_addr;
            logic [7:0] md_addr;
            logic [7:0] mx_addr;
            logic       en_ff;
            logic [1:0] hyp_ff;
            logic [1:0] hyn_ff;
            logic [1:0] mode_ff;
            logic       rie_ff;
            logic       fie_ff;
            logic [1:0] pos_ff;
            logic [1:0] neg_ff;
            logic       meta_ff;
            logic       sync_ff;
            logic       last_ff;
            logic       rif_ff;
            logic       fif_ff;
            logic       nxt_rif;
            logic       nxt_fif;
            logic       ctl_hit;
            logic       md_hit;
            logic       mx_hit;
            logic       rise;
            logic       fall;

            assign ctl_addr = (g == 0) ? arc_pkg::ADDR_CMP0_CONTROL
                                       : arc_pkg::ADDR_CMP1_CONTROL;
            assign md_addr  = (g == 0) ? arc_pkg::ADDR_CMP0_MODE
                                       : arc_pkg::ADDR_CMP1_MODE;
            assign mx_addr  = (g == 0) ? arc_pkg::ADDR_CMP0_INPUT_SELECT
                                       : arc_pkg::ADDR_CMP1_INPUT_SELECT;
            assign ctl_hit  = sfr_wr && (sfr_addr == ctl_addr);
            assign md_hit   = sfr_wr && (sfr_addr == md_addr);
            assign mx_hit   = sfr_wr && (sfr_addr == mx_addr);

            // Edge seen on the synchronised level, once per change
            assign rise = sync_ff & ~last_ff;
            assign fall = ~sync_ff & last_ff;

            // A set in the same cycle as a software clear wins
            assign nxt_rif = rise | (ctl_hit ?
                sfr_wdata[arc_pkg::CTL_RISING_BIT] : rif_ff);
            assign nxt_fif = fall | (ctl_hit ?
                sfr_wdata[arc_pkg::CTL_FALLING_BIT] : fif_ff);

            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    en_ff  <= 1'b0;
                    hyp_ff <= arc_pkg::RST_HYST;
                    hyn_ff <= arc_pkg::RST_HYST;
                    rif_ff <= 1'b0;
                    fif_ff <= 1'b0;
                end else begin
                    if (ctl_hit) begin
                        en_ff  <= sfr_wdata[arc_pkg::CTL_ENABLE_BIT];
                        hyp_ff <= sfr_wdata[arc_pkg::CTL_HYP_LSB +: 2];
                        hyn_ff <= sfr_wdata[arc_pkg::CTL_HYN_LSB +: 2];
                    end
                    rif_ff <= nxt_rif;
                    fif_ff <= nxt_fif;
                end
            end

            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    mode_ff <= arc_pkg::RST_MODE;
                    rie_ff  <= 1'b0;
                    fie_ff  <= 1'b0;
                    pos_ff  <= arc_pkg::RST_INPUT;
                    neg_ff  <= arc_pkg::RST_INPUT;
                end else begin
                    if (md_hit) begin
                        mode_ff <= sfr_wdata[arc_pkg::MD_MODE_LSB +: 2];
                        rie_ff  <= sfr_wdata[arc_pkg::MD_RIE_BIT];
                        fie_ff  <= sfr_wdata[arc_pkg::MD_FIE_BIT];
                    end
                    if (mx_hit) begin
                        pos_ff <= sfr_wdata[arc_pkg::MX_POS_LSB +: 2];
                        neg_ff <= sfr_wdata[arc_pkg::MX_NEG_LSB +: 2];
                    end
                end
            end

            // Two-stage synchroniser; only the second stage is looked at
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_ff <= 1'b0;
                    sync_ff <= 1'b0;
                    last_ff <= 1'b0;
                end else begin
                    meta_ff <= raw_comparator_output[g];
                    sync_ff <= meta_ff;
                    last_ff <= sync_ff;
                end
            end

            // Raw path has no flop so it still works with the clock stopped
            assign raw_comparator_output[g] =
                cmp_analog_out[g] & en_ff;
            assign latched_cmp_output[g] = sync_ff & en_ff;
            assign cmp_irq[g] = (rif_ff & rie_ff) | (fif_ff & fie_ff);

            // Mode and hysteresis codes go to the analog cell unchanged
            assign cmp_cfg[g].enable                     = en_ff;
            assign cmp_cfg[g].response_mode_field        = mode_ff;
            assign cmp_cfg[g].positive_hysteresis_select = hyp_ff;
            assign cmp_cfg[g].negative_hysteresis_select = hyn_ff;
            assign cmp_cfg[g].positive_input_field       = pos_ff;
            assign cmp_cfg[g].negative_input_field       = neg_ff;

            assign ctl_read[g] = {en_ff, sync_ff & en_ff,
                                  rif_ff, fif_ff, hyp_ff, hyn_ff};
            assign md_read[g]  = {2'b00, rie_ff, fie_ff, 2'b00, mode_ff};
            assign mx_read[g]  = {2'b00, neg_ff, 2'b00, pos_ff};
        end
    endgenerate

    // Only comparator 0 feeds the reset logic
    assign cmp0_reset_source = raw_comparator_output[0];

    // ****************************************************************
    // Read data
    // ****************************************************************
    logic [7:0] read_mux;
    logic [7:0] rdata_ff;

    always_comb begin
        read_mux = 8'h00;
        if (sfr_addr == arc_pkg::ADDR_REFERENCE_CONTROL) begin
            read_mux = ref_read;
        end
        for (int i = 0; i < NUM_CMP; i++) begin
            if (sfr_addr == g_cmp_addr(i, 0)) begin
                read_mux = ctl_read[i];
            end
            if (sfr_addr == g_cmp_addr(i, 1)) begin
                read_mux = md_read[i];
            end
            if (sfr_addr == g_cmp_addr(i, 2)) begin
                read_mux = mx_read[i];
            end
        end
    end

    function automatic logic [7:0] g_cmp_addr(input int idx, input int kind);
        logic [7:0] a;
        a = 8'h00;
        case (kind)
            0: a = (idx == 0) ? arc_pkg::ADDR_CMP0_CONTROL
                              : arc_pkg::ADDR_CMP1_CONTROL;
            1: a = (idx == 0) ? arc_pkg::ADDR_CMP0_MODE
                              : arc_pkg::ADDR_CMP1_MODE;
            default: a = (idx == 0) ? arc_pkg::ADDR_CMP0_INPUT_SELECT
                                    : arc_pkg::ADDR_CMP1_INPUT_SELECT;
        endcase
        return a;
    endfunction

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff <= arc_pkg::RST_READ_DATA;
        end else if (sfr_rd) begin
            rdata_ff <= read_mux;
        end
    end

    assign sfr_rdata = rdata_ff;
endmodule
`default_nettype wire

// [tb/arc_ctrl_sva.sv]
// Checker: port-level properties of the analog control block
`default_nettype none
module arc_ctrl_sva #(
    parameter int NUM_CMP = 2
) (
    // Clock and reset
    input wire logic                           ref_clk,
    input wire logic                           arst_n,
    // Register port
    input wire logic [7:0]                     sfr_addr,
    input wire logic                           sfr_wr,
    input wire logic                           sfr_rd,
    input wire logic [7:0]                     sfr_wdata,
    input wire logic [7:0]                     sfr_rdata,
    // Reference
    input wire logic                           reference_level_select,
    input wire logic                           zero_tc_bias_force,
    input wire logic                           bias_request,
    input wire arc_pkg::arc_ref_ctl_t          ref_ctl,
    // Comparators
    input wire logic [NUM_CMP-1:0]             cmp_analog_out,
    input wire arc_pkg::arc_cmp_cfg_t [NUM_CMP-1:0] cmp_cfg,
    input wire logic [NUM_CMP-1:0]             raw_comparator_output,
    input wire logic [NUM_CMP-1:0]             latched_cmp_output,
    input wire logic [NUM_CMP-1:0]             cmp_irq,
    input wire logic                           cmp0_reset_source
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    wire logic [1:0] en = {cmp_cfg[1].enable, cmp_cfg[0].enable};

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    raw_gate_a: assert property (raw_comparator_output == (cmp_analog_out & en))
        else $error("raw output not gated by enable");
    reset_src_a: assert property (cmp0_reset_source == raw_comparator_output[0])
        else $error("reset source differs from raw output");
    bias_demand_a: assert property (bias_request |-> ref_ctl.bias_on)
        else $error("bias off while requested");
    latch_rise_a: assert property (raw_comparator_output[0] [*3] |-> latched_cmp_output[0])
        else $error("latched output missed a high level");
    latch_fall_a: assert property (!cmp_analog_out[1] [*3] |-> !latched_cmp_output[1])
        else $error("latched output missed a low level");
    latch_off_a: assert property (!en[0] |-> !latched_cmp_output[0])
        else $error("latched output high while disabled");
    flag_hold_a: assert property (cmp_irq[0] && !sfr_wr |=> cmp_irq[0])
        else $error("edge request dropped without a write");
    // Look at the raw level three and four edges back, the point that the
    // two sync stages and the edge detect act on; the gated latched output
    // would miss the fall that comes from disabling a high comparator
    irq_cause_a: assert property ($rose(cmp_irq[0]) |-> $past(sfr_wr) ||
        ($past(raw_comparator_output[0], 3) !=
         $past(raw_comparator_output[0], 4)))
        else $error("edge request raised without an edge");
    cfg_hold_a: assert property (!sfr_wr |=> $stable(cmp_cfg))
        else $error("comparator settings changed without a write");
    ref_hold_a: assert property (!sfr_wr |=> $stable({ref_ctl.reference_source_select,
        ref_ctl.temp_sensor_enable, ref_ctl.reference_buffer_enable}))
        else $error("reference controls changed without a write");
endmodule

bind arc_ctrl arc_ctrl_sva #(.NUM_CMP(NUM_CMP)) i_sva (.ref_clk, .arst_n,
    .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .reference_level_select, .zero_tc_bias_force, .bias_request, .ref_ctl,
    .cmp_analog_out, .cmp_cfg, .raw_comparator_output, .latched_cmp_output,
    .cmp_irq, .cmp0_reset_source);
`default_nettype wire

// [tb/tb_arc_ctrl.sv]
// Testbench: self-checking run of the analog control block
`default_nettype none
module tb_arc_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Signals and design
    // ****************************************************************
    logic                          ref_clk = 1'b0;
    logic                          arst_n = 1'b0;
    logic [7:0]                    sfr_addr = 8'h00;
    logic                          sfr_wr = 1'b0;
    logic                          sfr_rd = 1'b0;
    logic [7:0]                    sfr_wdata = 8'h00;
    logic [7:0]                    sfr_rdata;
    logic                          reference_level_select = 1'b0;
    logic                          zero_tc_bias_force = 1'b0;
    logic                          bias_request = 1'b0;
    arc_pkg::arc_ref_ctl_t         ref_ctl;
    logic [1:0]                    cmp_analog_out = 2'h0;
    arc_pkg::arc_cmp_cfg_t [1:0]   cmp_cfg;
    logic [1:0]                    raw_comparator_output;
    logic [1:0]                    latched_cmp_output;
    logic [1:0]                    cmp_irq;
    logic                          cmp0_reset_source;
    int                            n_mismatch = 0;
    int                            checks_done = 0;

    arc_ctrl i_dut (.ref_clk, .arst_n, .sfr_addr, .sfr_wr, .sfr_rd,
        .sfr_wdata, .sfr_rdata, .reference_level_select,
        .zero_tc_bias_force, .bias_request, .ref_ctl, .cmp_analog_out,
        .cmp_cfg, .raw_comparator_output, .latched_cmp_output, .cmp_irq,
        .cmp0_reset_source);

    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    // ****************************************************************
    // Bus and compare tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge ref_clk);
        sfr_rd = 1'b0;
        chk(nm, e, sfr_rdata);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        logic [7:0] ad [8] = '{8'hD1, 8'h9A, 8'h9B, 8'h9D,
                               8'h9E, 8'h9F, 8'h9C, 8'h55};
        logic [7:0] ex [8] = '{8'h00, 8'h00, 8'h02, 8'h00,
                               8'h02, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 8; i++) begin
            rd(ad[i], ex[i], "reset value");
        end
    endtask

    task automatic t_ref();
        for (int i = 0; i < 4; i++) begin
            wr(8'hD1, 8'hC0 | (8'h01 << i));
            chk("ref_ctl", 8'h01 << i, {4'h0, ref_ctl});
            rd(8'hD1, 8'h01 << i, "ref readback");
        end
        reference_level_select = 1'b1;
        zero_tc_bias_force = 1'b1;
        rd(8'hD1, 8'h38, "ref status");
        wr(8'hD1, 8'h00);
        bias_request = 1'b1;
        @(negedge ref_clk);
        chk("bias on demand", 8'h02, {4'h0, ref_ctl});
        bias_request = 1'b0;
    endtask

    task automatic t_cmp(input int n);
        logic [7:0] c;
        logic [7:0] md;
        logic [7:0] mx;
        c = n ? 8'h9D : 8'h9A;
        md = n ? 8'h9E : 8'h9B;
        mx = n ? 8'h9C : 8'h9F;
        wr(c, 8'h80);
        wr(md, 8'h32);
        // Flags are cleared after enabling and after setting both interrupt enables
        wr(c, 8'h80);
        cmp_analog_out[n] = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("raw out", 8'h01, raw_comparator_output[n]);
        chk("latched out", 8'h01, latched_cmp_output[n]);
        chk("irq rise", 8'h01, cmp_irq[n]);
        chk("reset source", n ? 8'h00 : 8'h01, cmp0_reset_source);
        rd(c, 8'hE0, "rising flag");
        wr(c, 8'h80);
        rd(c, 8'hC0, "flag cleared");
        cmp_analog_out[n] = 1'b0;
        repeat (4) @(negedge ref_clk);
        rd(c, 8'h90, "falling flag");
        repeat (8) @(negedge ref_clk);
        rd(c, 8'h90, "flag sticky");
        wr(md, 8'h22);
        chk("irq masked", 8'h00, cmp_irq[n]);
        wr(md, 8'h12);
        chk("irq fall", 8'h01, cmp_irq[n]);
        wr(c, 8'h0D);
        cmp_analog_out[n] = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("raw off", 8'h00, raw_comparator_output[n]);
        chk("latched off", 8'h00, latched_cmp_output[n]);
        chk("hysteresis", 8'h0D, {4'h0, cmp_cfg[n].positive_hysteresis_select,
            cmp_cfg[n].negative_hysteresis_select});
        rd(c, 8'h0D, "disabled ctl");
        wr(mx, 8'hFF);
        rd(mx, 8'h33, "input select");
        chk("input fields", 8'h0F, {4'h0, cmp_cfg[n].positive_input_field,
            cmp_cfg[n].negative_input_field});
        wr(md, 8'hFF);
        rd(md, 8'h33, "mode reg");
        chk("mode field", 8'h03, {6'h0, cmp_cfg[n].response_mode_field});
        cmp_analog_out[n] = 1'b0;
    endtask

    // ****************************************************************
    // Sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (3) @(negedge ref_clk);
        arst_n = 1'b1;
        t_reset();
        t_ref();
        t_cmp(0);
        t_cmp(1);
        report_and_stop();
    end

    // Run needs well under a thousand cycles
    initial begin
        #200000;
        n_mismatch++;
        report_and_stop();
    end
endmodule
`default_nettype wire
